/* fsol_pkg.sv */
// shared constants for the flash security option loader
package fsol_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int KEY_BYTES = 8;
    // register byte addresses
    localparam logic [15:0] ADDR_OPT_WORK = 16'h1821;
    localparam logic [15:0] ADDR_PROT_WORK = 16'h1824;
    localparam logic [15:0] ADDR_KEY_BASE = 16'hffb0;
    localparam logic [15:0] ADDR_NV_PROT = 16'hffbd;
    localparam logic [15:0] ADDR_NV_OPT = 16'hffbf;
    // own control and status registers
    localparam logic [15:0] ADDR_KEY_ENTRY = 16'h1828;
    localparam logic [15:0] ADDR_SEC_STATUS = 16'h1829;
    localparam logic [15:0] ADDR_KEY_MASK = 16'hfff8;
    // option byte fields
    localparam int OPT_BACKDOOR_KEY_ENABLE_BIT = 7;
    localparam int OPT_NORED_BIT = 6;
    localparam int OPT_SECH_BIT = 1;
    localparam int OPT_SECL_BIT = 0;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [7:0] OPT_RSVD_MASK = 8'hc3;
    // protection byte fields
    localparam int PROT_DIS_BIT = 0;
    // status register bits
    localparam int STAT_SECURE_BIT = 0;
    localparam int STAT_BACKDOOR_BIT = 1;
    localparam int STAT_LOADED_BIT = 2;
    localparam int STAT_BLANK_BIT = 3;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [2:0] IDX_ZERO = 3'h0;
    localparam logic [2:0] IDX_LAST = 3'h7;
    localparam logic [2:0] IDX_ONE = 3'h1;
    localparam logic [7:0] NV_ADDR_KEY0 = 8'hb0;
    localparam logic [7:0] NV_ADDR_PROT = 8'hbd;
    localparam logic [7:0] NV_ADDR_OPT = 8'hbf;
endpackage : fsol_pkg

/* fsol_nv_if.sv */
// read port from the loader to the nonvolatile flash area
`timescale 1ns/100ps
`default_nettype none
interface fsol_nv_if;
    logic rd_req;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    modport loader (output rd_req, output rd_addr, input rd_data);
    modport array (input rd_req, input rd_addr, output rd_data);
endinterface : fsol_nv_if
`default_nettype wire

/* fsol_nv_mux.sv */
// sampled access from loader into the nonvolatile byte inputs
`timescale 1ns/100ps
`default_nettype none
module fsol_nv_mux (
    input wire logic clk_i, // system clock
    input wire logic [63:0] key_i, // comparison key bytes from flash
    input wire logic [7:0] prot_i, // protection byte from flash
    input wire logic [7:0] opt_i, // option byte from flash
    fsol_nv_if.array nv // read port
);
    import fsol_pkg::*;
    logic [7:0] next_data;
    logic [7:0] data;
    always_comb begin
        next_data = data;
        if (nv.rd_req) begin
            if (nv.rd_addr == NV_ADDR_PROT) begin
                next_data = prot_i;
            end else if (nv.rd_addr == NV_ADDR_OPT) begin
                next_data = opt_i;
            end else begin
                next_data = key_i[8*(nv.rd_addr[2:0]) +: 8];
            end
        end
    end
    always_ff @(posedge clk_i) begin
        data <= next_data;
    end
    assign nv.rd_data = data;
endmodule : fsol_nv_mux
`default_nettype wire

/* fsol_key_cmp.sv */
// byte-serial backdoor key comparator
`timescale 1ns/100ps
`default_nettype none
module fsol_key_cmp #(
    parameter int NBYTES = 8 // key length in bytes
) (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // sync reset
    input wire logic wr_i, // one key byte written
    input wire logic [7:0] wr_byte_i, // byte written
    input wire logic [7:0] ref_byte_i, // stored key byte at index
    output logic [2:0] idx_o, // index of next byte
    output logic done_o, // pulse: last byte taken
    output logic match_o // pulse: all bytes equal
);
    import fsol_pkg::*;
    logic [2:0] idx;
    logic ok;
    logic [2:0] next_idx;
    logic next_ok;
    logic last;
    assign last = (idx == 3'(NBYTES - 1));
    always_comb begin
        next_idx = idx;
        next_ok = ok;
        if (wr_i) begin
            next_ok = ok & (wr_byte_i == ref_byte_i);
            next_idx = idx + IDX_ONE;
            if (last) begin
                next_idx = IDX_ZERO;
                next_ok = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx <= IDX_ZERO;
            ok <= 1'b1;
        end else begin
            idx <= next_idx;
            ok <= next_ok;
        end
    end
    assign idx_o = idx;
    assign done_o = wr_i & last;
    assign match_o = wr_i & last & ok & (wr_byte_i == ref_byte_i);
endmodule : fsol_key_cmp
`default_nettype wire

/* fsol_top.sv */
// flash security option loader with wishbone register slave
`timescale 1ns/100ps
`default_nettype none
module fsol_top (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // sync reset, active high
    input wire logic [fsol_pkg::ADDR_W-1:0] wb_adr_i, // byte address
    input wire logic [fsol_pkg::DATA_W-1:0] wb_dat_i, // write data
    output logic [fsol_pkg::DATA_W-1:0] wb_dat_o, // read data
    input wire logic wb_we_i, // write enable
    input wire logic wb_sel_i, // byte select
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    output logic wb_ack_o, // acknowledge
    input wire logic cpu_secure_code_i, // fetch from secure memory
    input wire logic dbg_access_i, // access by background debug
    input wire logic [63:0] nv_key_i, // comparison key in flash
    input wire logic [7:0] nv_prot_i, // protection byte in flash
    input wire logic [7:0] nv_opt_i, // option byte in flash
    input wire logic flash_blank_verified_i, // pulse: blank after erase
    input wire logic ram_req_i, // RAM access attempt
    output logic ram_grant_o, // RAM access allowed
    output logic secure_o, // security engaged
    output logic vector_redirect_disable_o, // option bit
    output logic protection_disable_o, // protection off
    output logic [6:0] block_protect_o // protected block size
);
    import fsol_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_PROT = 5'b00010,
        ST_OPT = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_RUN = 5'b10000
    } fsol_state_t;

    fsol_nv_if nv ();

    fsol_state_t state;
    fsol_state_t next_state;
    logic [7:0] opt_work;
    logic [7:0] next_opt_work;
    logic [7:0] prot_work;
    logic [7:0] next_prot_work;
    logic backdoor_open;
    logic next_backdoor_open;
    logic blank_open;
    logic next_blank_open;
    logic ack;
    logic next_ack;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic [7:0] key_ref;
    logic [7:0] next_key_ref;
    logic [2:0] key_idx;
    logic key_match;
    logic key_wr;
    logic req;
    logic wr_req;
    logic secure;

    function automatic logic is_key_addr(input logic [15:0] a);
        return (a & ADDR_KEY_MASK) == ADDR_KEY_BASE;
    endfunction : is_key_addr

    fsol_nv_mux u_nv (
        .clk_i (clk_i),
        .key_i (nv_key_i),
        .prot_i (nv_prot_i),
        .opt_i (nv_opt_i),
        .nv (nv.array)
    );

    // debug key-entry writes are dropped, so the key cannot come from debug
    assign req = wb_cyc_i & wb_stb_i & ~ack;
    assign wr_req = req & wb_we_i & wb_sel_i;
    assign key_wr = wr_req & (wb_adr_i == ADDR_KEY_ENTRY)
        & cpu_secure_code_i & ~dbg_access_i
        & opt_work[OPT_BACKDOOR_KEY_ENABLE_BIT]
        & (state == ST_RUN);

    fsol_key_cmp #(.NBYTES(KEY_BYTES)) u_cmp (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .wr_i (key_wr),
        .wr_byte_i (wb_dat_i),
        .ref_byte_i (key_ref),
        .idx_o (key_idx),
        .done_o (),
        .match_o (key_match)
    );

    // reload sequence: protection byte, option byte, first key byte, then run
    always_comb begin
        next_state = state;
        nv.rd_req = 1'b0;
        nv.rd_addr = NV_ADDR_PROT;
        unique case (state)
            ST_IDLE: begin
                nv.rd_req = 1'b1;
                next_state = ST_PROT;
            end
            ST_PROT: begin
                nv.rd_req = 1'b1;
                nv.rd_addr = NV_ADDR_OPT;
                next_state = ST_OPT;
            end
            ST_OPT: begin
                nv.rd_req = 1'b1;
                nv.rd_addr = NV_ADDR_KEY0;
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                nv.rd_req = 1'b1;
                nv.rd_addr = NV_ADDR_KEY0 | {5'h00, key_idx};
                next_state = ST_RUN;
            end
            ST_RUN: begin
                // keep the reference byte tracking the comparator index
                nv.rd_req = 1'b1;
                nv.rd_addr = NV_ADDR_KEY0 | {5'h00, key_idx + IDX_ONE};
                if (!key_wr) begin
                    nv.rd_addr = NV_ADDR_KEY0 | {5'h00, key_idx};
                end
                if (key_wr && key_idx == IDX_LAST) begin
                    nv.rd_addr = NV_ADDR_KEY0;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // working copies and unsecure latches
    always_comb begin
        next_prot_work = prot_work;
        next_opt_work = opt_work;
        next_backdoor_open = backdoor_open;
        next_blank_open = blank_open;
        next_key_ref = nv.rd_data;
        // read data lags its request by one state
        if (state == ST_PROT) begin
            next_prot_work = nv.rd_data;
        end
        if (state == ST_OPT) begin
            next_opt_work = nv.rd_data & OPT_RSVD_MASK;
        end
        if (key_match) begin
            next_backdoor_open = 1'b1;
        end
        if (flash_blank_verified_i && state == ST_RUN) begin
            next_blank_open = 1'b1;
        end
        if (wr_req && wb_adr_i == ADDR_PROT_WORK && state == ST_RUN) begin
            next_prot_work = wb_dat_i;
        end
    end

    // field value 1:0 is the only unsecured code
    assign secure = (state != ST_RUN)
        || ((opt_work[OPT_SECH_BIT:OPT_SECL_BIT] != SEC_UNSECURED)
            && !backdoor_open && !blank_open);

    // bus read mux; unmapped addresses read zero and still ack
    always_comb begin
        next_ack = req;
        next_rdata = BYTE_ZERO;
        if (req && !wb_we_i) begin
            if (wb_adr_i == ADDR_OPT_WORK) begin
                next_rdata = opt_work;
            end else if (wb_adr_i == ADDR_PROT_WORK) begin
                next_rdata = prot_work;
            end else if (wb_adr_i == ADDR_NV_PROT) begin
                next_rdata = nv_prot_i;
            end else if (wb_adr_i == ADDR_NV_OPT) begin
                next_rdata = nv_opt_i;
            end else if (wb_adr_i == ADDR_SEC_STATUS) begin
                next_rdata[STAT_SECURE_BIT] = secure;
                next_rdata[STAT_BACKDOOR_BIT] = backdoor_open;
                next_rdata[STAT_LOADED_BIT] = (state == ST_RUN);
                next_rdata[STAT_BLANK_BIT] = blank_open;
            end else if (is_key_addr(wb_adr_i)) begin
                // key reads out only once unsecured, never while secure
                if (!secure) begin
                    next_rdata = nv_key_i[8*wb_adr_i[2:0] +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            opt_work <= BYTE_ZERO;
            prot_work <= BYTE_ZERO;
            backdoor_open <= 1'b0;
            blank_open <= 1'b0;
            ack <= 1'b0;
            rdata <= BYTE_ZERO;
            key_ref <= BYTE_ZERO;
        end else begin
            state <= next_state;
            opt_work <= next_opt_work;
            prot_work <= next_prot_work;
            backdoor_open <= next_backdoor_open;
            blank_open <= next_blank_open;
            ack <= next_ack;
            rdata <= next_rdata;
            key_ref <= next_key_ref;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign secure_o = secure;
    // secure RAM refused to debug and nonsecure code
    assign ram_grant_o = ram_req_i
        & (~secure | (cpu_secure_code_i & ~dbg_access_i));
    assign vector_redirect_disable_o = opt_work[OPT_NORED_BIT];
    assign protection_disable_o = prot_work[PROT_DIS_BIT];
    assign block_protect_o = prot_work[7:1];
endmodule : fsol_top
`default_nettype wire

/* fsol_top_asserts.sv */
// port-level assertions for the security option loader
`timescale 1ns/100ps
`default_nettype none
module fsol_top_asserts (
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic [fsol_pkg::ADDR_W-1:0] wb_adr_i, // address
    input wire logic wb_we_i, // write
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_ack_o, // ack
    input wire logic cpu_secure_code_i, // secure code
    input wire logic dbg_access_i, // debug
    input wire logic [7:0] nv_prot_i, // prot byte
    input wire logic [7:0] nv_opt_i, // option byte
    input wire logic flash_blank_verified_i, // blank done
    input wire logic ram_req_i, // ram request
    input wire logic ram_grant_o, // ram grant
    input wire logic secure_o, // secured
    input wire logic vector_redirect_disable_o, // opt bit
    input wire logic protection_disable_o, // prot bit
    input wire logic [6:0] block_protect_o // prot size
);
    import fsol_pkg::*;
    logic [2:0] age;
    logic [2:0] next_age;
    logic opened;
    logic next_opened;
    logic take;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // age hides the drop caused by loading an unsecured field
    always_comb begin
        next_age = (age == 3'h7) ? age : age + 3'h1;
        next_opened = opened || flash_blank_verified_i
            || (take && wb_we_i && wb_adr_i == ADDR_KEY_ENTRY
            && cpu_secure_code_i && !dbg_access_i
            && nv_opt_i[OPT_BACKDOOR_KEY_ENABLE_BIT]);
        if (rst_i) begin
            next_age = 3'h0;
            next_opened = 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        age <= next_age;
        opened <= next_opened;
    end
    sequence s_loaded;
        $fell(rst_i) ##4 1'b1;
    endsequence
    a_ack_next: assert property (take |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_load_work: assert property (s_loaded |->
        block_protect_o == nv_prot_i[7:1]
        && protection_disable_o == nv_prot_i[PROT_DIS_BIT]
        && vector_redirect_disable_o == nv_opt_i[OPT_NORED_BIT])
        else $error("working bytes not loaded");
    a_sec_field: assert property (s_loaded |->
        secure_o == (nv_opt_i[1:0] != SEC_UNSECURED))
        else $error("security field misread");
    a_ram_block: assert property (ram_grant_o == (ram_req_i
        && (!secure_o || (cpu_secure_code_i && !dbg_access_i))))
        else $error("ram grant wrong");
    a_sec_sticky: assert property (!secure_o |=> !secure_o)
        else $error("security re-engaged without reset");
    a_open_gate: assert property ($fell(secure_o) && age == 3'h7
        |-> opened)
        else $error("security dropped without key or blank");
endmodule : fsol_top_asserts
`default_nettype wire

/* fsol_top_tb.sv */
// self-checking bench for the security option loader
`timescale 1ns/100ps
`default_nettype none
module fsol_top_tb;
    import fsol_pkg::*;
    localparam logic [63:0] KEY = 64'h0123456789abcdef; // arbitrary
    logic clk_i = 1'b0;
    logic rst_i, we, cyc, stb, sc, dbg, blank, rreq, sel;
    logic ack, grant, sec, nored, pdis;
    logic [15:0] adr;
    logic [7:0] wd, rd, got, prot, opt;
    logic [6:0] bp;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    fsol_top fsol_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wd), .wb_dat_o(rd), .wb_we_i(we), .wb_sel_i(sel),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .cpu_secure_code_i(sc), .dbg_access_i(dbg), .nv_key_i(KEY),
        .nv_prot_i(prot), .nv_opt_i(opt), .flash_blank_verified_i(blank),
        .ram_req_i(rreq), .ram_grant_o(grant), .secure_o(sec),
        .vector_redirect_disable_o(nored), .protection_disable_o(pdis),
        .block_protect_o(bp));
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 5000) begin
            fail_count++;
            stop_test;
        end
    end
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic [15:0] a, input logic w,
        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr <= a;
        we <= w;
        wd <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        got = rd;
        chk("ack", 8'h01, {7'h00, ack});
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus
    task automatic boot(input logic [7:0] p, input logic [7:0] o);
        @(posedge clk_i);
        prot <= p;
        opt <= o;
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : boot
    // bounded wait: compare latency is not fixed by the hand-over
    task automatic settle;
        int n;
        n = 0;
        while (sec === 1'b1 && n < 10) begin
            @(posedge clk_i);
            n++;
        end
    endtask : settle
    task automatic key(input logic [63:0] k);
        for (int i = 0; i < KEY_BYTES; i++) begin
            bus(ADDR_KEY_ENTRY, 1'b1, k[8*i +: 8]);
        end
        settle;
    endtask : key
    task automatic t_load;
        boot(8'h5b, 8'hfd);
        chk("bp", 8'h2d, {1'b0, bp});
        chk("pdis nored", 8'h03, {6'h00, pdis, nored});
        chk("sec", 8'h01, {7'h00, sec});
        bus(ADDR_OPT_WORK, 1'b1, 8'h02);
        bus(ADDR_OPT_WORK, 1'b0, 8'h00);
        chk("opt", 8'hfd & OPT_RSVD_MASK, got);
        bus(ADDR_NV_OPT, 1'b0, 8'h00);
        chk("nv opt", 8'hfd, got);
        bus(ADDR_NV_PROT, 1'b0, 8'h00);
        chk("nv prot", 8'h5b, got);
        bus(ADDR_PROT_WORK, 1'b1, 8'h3a);
        bus(ADDR_PROT_WORK, 1'b0, 8'h00);
        chk("prot", 8'h3a, got);
        chk("bp rw", 8'h1d, {1'b0, bp});
        sel <= 1'b0;
        bus(ADDR_PROT_WORK, 1'b1, 8'h77);
        sel <= 1'b1;
        bus(ADDR_PROT_WORK, 1'b0, 8'h00);
        chk("prot no sel", 8'h3a, got);
        bus(16'h1830, 1'b0, 8'h00);
        chk("unmapped", 8'h00, got);
        bus(ADDR_KEY_BASE, 1'b0, 8'h00);
        chk("key hidden", 8'h00, got);
        $display("test load done");
    endtask : t_load
    task automatic t_key;
        rreq <= 1'b1;
        dbg <= 1'b1;
        sc <= 1'b1;
        @(posedge clk_i);
        chk("grant dbg", 8'h00, {7'h00, grant});
        dbg <= 1'b0;
        @(posedge clk_i);
        chk("grant sc", 8'h01, {7'h00, grant});
        sc <= 1'b0;
        key(KEY);
        chk("sec nonsecure", 8'h01, {7'h00, sec});
        sc <= 1'b1;
        dbg <= 1'b1;
        key(KEY);
        chk("sec debug", 8'h01, {7'h00, sec});
        dbg <= 1'b0;
        key(KEY ^ 64'h0100000000000000);
        chk("sec bad key", 8'h01, {7'h00, sec});
        key(KEY);
        chk("sec open", 8'h00, {7'h00, sec});
        bus(ADDR_SEC_STATUS, 1'b0, 8'h00);
        chk("status open", 8'h06, got);
        bus(ADDR_KEY_BASE | 16'h0001, 1'b0, 8'h00);
        chk("key byte1", KEY[15:8], got);
        dbg <= 1'b1;
        sc <= 1'b0;
        @(posedge clk_i);
        chk("grant open", 8'h01, {7'h00, grant});
        $display("test key done");
    endtask : t_key
    task automatic t_nokey;
        boot(8'h00, 8'h00);
        dbg <= 1'b0;
        sc <= 1'b1;
        key(KEY);
        chk("sec nokey", 8'h01, {7'h00, sec});
        blank <= 1'b1;
        @(posedge clk_i);
        blank <= 1'b0;
        settle;
        chk("sec blank", 8'h00, {7'h00, sec});
        bus(ADDR_SEC_STATUS, 1'b0, 8'h00);
        chk("status blank", 8'h0c, got);
        boot(8'h00, 8'h00);
        chk("sec reset", 8'h01, {7'h00, sec});
        $display("test nokey done");
    endtask : t_nokey
    task automatic t_field;
        for (int i = 0; i < 4; i++) begin
            boot(8'h00, {6'h20, i[1:0]});
            chk("sec field", {7'h00, i != 2}, {7'h00, sec});
        end
        $display("test field done");
    endtask : t_field
    initial begin
        rst_i = 1'b1;
        adr = 16'h0000;
        wd = 8'h00;
        {we, cyc, stb, sc, dbg, blank, rreq} = 7'h00;
        sel = 1'b1;
        prot = 8'h00;
        opt = 8'h00;
        t_load;
        t_key;
        t_nokey;
        t_field;
        stop_test;
    end
endmodule : fsol_top_tb
bind fsol_top fsol_top_asserts fsol_top_asserts_i (.clk_i, .rst_i,
    .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .cpu_secure_code_i, .dbg_access_i, .nv_prot_i, .nv_opt_i,
    .flash_blank_verified_i, .ram_req_i, .ram_grant_o, .secure_o,
    .vector_redirect_disable_o, .protection_disable_o, .block_protect_o);
`default_nettype wire
